// File: design/spc_defs.vh
// constants of the scaled pulse counter: register map, fields, reset values
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// ==========================================
// register byte offsets
`define SPC_OFF_CTRL 8'h00
`define SPC_OFF_SCALE 8'h04
`define SPC_OFF_TOT_SCALE 8'h08
`define SPC_OFF_PROC_LO 8'h0c
`define SPC_OFF_PROC_HI 8'h10
`define SPC_OFF_TOT_LO 8'h14
`define SPC_OFF_TOT_HI 8'h18
`define SPC_OFF_EDGES 8'h1c
`define SPC_OFF_STATUS 8'h20

// ==========================================
// control fields
`define SPC_CTRL_MODE_LSB 0
`define SPC_CTRL_MODE_MSB 1
`define SPC_CTRL_MULT_LSB 2
`define SPC_CTRL_MULT_MSB 3
`define SPC_CTRL_EN_BIT 4
`define SPC_CTRL_CLR_BIT 8

// ==========================================
// edge modes
`define SPC_MODE_SINGLE 2'h0
`define SPC_MODE_DOUBLE 2'h1
`define SPC_MODE_QUAD 2'h2

// ==========================================
// multiplier codes and factors in 1e-6 units per 1e-4 of scale factor
`define SPC_MULT_X1 2'h0
`define SPC_MULT_X0P1 2'h1
`define SPC_MULT_X0P01 2'h2
`define SPC_MFAC_X1 7'h64
`define SPC_MFAC_X0P1 7'h0a
`define SPC_MFAC_X0P01 7'h01

// ==========================================
// reset values and limits
`define SPC_SCALE_RST 16'h2710
`define SPC_SCALE_MAX 16'hea5f
`define SPC_TOT_SCALE_RST 16'h2710
`define SPC_MODE_RST 2'h0
`define SPC_MULT_RST 2'h0
`define SPC_EN_RST 1'h1

`endif

// File: design/spc_sync.v
// pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module spc_sync
(
   input wire clk_sys,
   input wire reset_n,
   input wire pin,
   output reg level_q,
   output wire rise,
   output wire fall
);

   reg meta_q;
   reg prev_q;

   // ==========================================
   // two flops, then a history flop
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q <= 1'b0;
         level_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= pin;
         level_q <= meta_q;
         prev_q <= level_q;
      end
   end

   assign rise = level_q & ~prev_q;
   assign fall = ~level_q & prev_q;

endmodule

`default_nettype wire

// File: design/spc_accum.v
// signed accumulator stepping up or down by a scaled amount
`timescale 1ns/1ps
`default_nettype none

module spc_accum
#(
   parameter W = 64,
   parameter SW = 39
)
(
   input wire clk_sys,
   input wire reset_n,
   input wire clear,
   input wire add_en,
   input wire down,
   input wire [SW-1:0] step,
   output reg [W-1:0] value_q
);

   wire [W-1:0] step_ext;
   reg [W-1:0] value_d;

   assign step_ext = {{(W-SW){1'b0}}, step};

   // ==========================================
   // full step per counted edge only
   always @*
   begin
      value_d = value_q;
      if (clear)
      begin
         value_d = {W{1'b0}};
      end
      else if (add_en)
      begin
         if (down)
         begin
            value_d = value_q - step_ext;
         end
         else
         begin
            value_d = value_q + step_ext;
         end
      end
   end

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         value_q <= {W{1'b0}};
      end
      else
      begin
         value_q <= value_d;
      end
   end

endmodule

`default_nettype wire

// File: design/spc_top.v
// scaled pulse counter: edge decode, scaling, process and total, apb registers
// Function
// - default settings give exactly one process count per input pulse
// - single mode counts one edge per pulse, quadrature mode four per cycle
// - double mode counts both edges of each input pulse
// - scaling is scale factor times multiplier times counted edges per pulse
// - multiplier and edge mode reset to times one
// - multiplier selectable as times one, 0.1 or 0.01
// - scale factor has four decimals, at most 5.9999
// - process value changes only on counted edges, by the full scaling, and on a control clear, which zeroes it
// - more edges per pulse lowers the highest usable input frequency
// - total scale factor resets to 1.0000, totalizer then tracks process
// - totalizer adds process step times total scale factor per edge
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.vh"

module spc_top
(
   input wire clk_sys,
   input wire reset_n,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire pulse_a,
   input wire dir_b
);

   // ==========================================
   // datapath widths, process step holds 5.9999 x 100 in 1e-6 units
   localparam PSW = 23;
   localparam TSW = 39;

   // ==========================================
   // configuration and state
   reg [1:0] mode_q;
   reg [1:0] mult_q;
   reg en_q;
   reg clr_q;
   reg [15:0] scale_q;
   reg [15:0] tot_scale_q;
   reg [31:0] proc_hi_snap_q;
   reg [31:0] tot_hi_snap_q;
   reg [31:0] edges_q;

   wire a_lvl;
   wire a_rise;
   wire a_fall;
   wire b_lvl;
   wire b_rise;
   wire b_fall;
   wire [63:0] proc_val;
   wire [63:0] tot_val;

   reg cnt_ev;
   reg cnt_dn;
   reg [6:0] mfac;
   reg [31:0] rdata_d;
   reg rd_ok;
   reg [15:0] wr_scale;

   wire [PSW-1:0] step_proc;
   wire [TSW-1:0] step_tot;
   wire [TSW-1:0] step_proc_ext;
   wire access;
   wire rd_first;
   wire wr_go;
   wire ev_go;

   // ==========================================
   // pin synchronisers
   spc_sync u_sync_a
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pin(pulse_a),
      .level_q(a_lvl),
      .rise(a_rise),
      .fall(a_fall)
   );

   spc_sync u_sync_b
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pin(dir_b),
      .level_q(b_lvl),
      .rise(b_rise),
      .fall(b_fall)
   );

   // ==========================================
   // edge qualification per mode
   always @*
   begin
      cnt_ev = 1'b0;
      cnt_dn = 1'b0;
      case (mode_q)
         `SPC_MODE_SINGLE:
         begin
            cnt_ev = a_rise;
            cnt_dn = b_lvl;
         end
         `SPC_MODE_DOUBLE:
         begin
            cnt_ev = a_rise | a_fall;
            cnt_dn = b_lvl;
         end
         `SPC_MODE_QUAD:
         begin
            // both channels moving at once is invalid and ignored
            cnt_ev = (a_rise | a_fall) ^ (b_rise | b_fall);
            if (a_rise | a_fall)
            begin
               cnt_dn = (a_lvl == b_lvl);
            end
            else
            begin
               cnt_dn = (a_lvl != b_lvl);
            end
         end
         default:
         begin
            cnt_ev = a_rise;
            cnt_dn = b_lvl;
         end
      endcase
   end

   // one edge per clock at most: extra edges per pulse eat input bandwidth
   assign ev_go = cnt_ev & en_q;

   // ==========================================
   // scaling
   always @*
   begin
      case (mult_q)
         `SPC_MULT_X0P1: mfac = `SPC_MFAC_X0P1;
         `SPC_MULT_X0P01: mfac = `SPC_MFAC_X0P01;
         default: mfac = `SPC_MFAC_X1;
      endcase
   end

   // per counted edge, so edges per pulse multiply in by counting
   assign step_proc = scale_q * mfac;
   assign step_tot = step_proc * tot_scale_q;
   assign step_proc_ext = {{(TSW-PSW){1'b0}}, step_proc};

   // process in 1e-6 counts
   spc_accum #(.W(64), .SW(TSW)) u_proc
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clear(clr_q),
      .add_en(ev_go),
      .down(cnt_dn),
      .step(step_proc_ext),
      .value_q(proc_val)
   );

   // totalizer in 1e-10 counts
   spc_accum #(.W(64), .SW(TSW)) u_tot
   (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clear(clr_q),
      .add_en(ev_go),
      .down(cnt_dn),
      .step(step_tot),
      .value_q(tot_val)
   );

   // ==========================================
   // apb slave, one wait state
   assign access = psel & penable;
   assign wr_go = access & pready & pwrite;
   // first access cycle of a read
   assign rd_first = access & ~pready & ~pwrite;

   always @*
   begin
      wr_scale = pwdata[15:0];
      if (pwdata[15:0] > `SPC_SCALE_MAX)
      begin
         wr_scale = `SPC_SCALE_MAX;
      end
   end

   always @*
   begin
      rdata_d = 32'h00000000;
      rd_ok = 1'b1;
      case (paddr)
         `SPC_OFF_CTRL:
         begin
            rdata_d[`SPC_CTRL_MODE_MSB:`SPC_CTRL_MODE_LSB] = mode_q;
            rdata_d[`SPC_CTRL_MULT_MSB:`SPC_CTRL_MULT_LSB] = mult_q;
            rdata_d[`SPC_CTRL_EN_BIT] = en_q;
         end
         `SPC_OFF_SCALE: rdata_d[15:0] = scale_q;
         `SPC_OFF_TOT_SCALE: rdata_d[15:0] = tot_scale_q;
         `SPC_OFF_PROC_LO: rdata_d = proc_val[31:0];
         `SPC_OFF_PROC_HI: rdata_d = proc_hi_snap_q;
         `SPC_OFF_TOT_LO: rdata_d = tot_val[31:0];
         `SPC_OFF_TOT_HI: rdata_d = tot_hi_snap_q;
         `SPC_OFF_EDGES: rdata_d = edges_q;
         `SPC_OFF_STATUS: rdata_d[1:0] = {b_lvl, a_lvl};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~rd_ok;
         if (rd_first)
         begin
            prdata <= rdata_d;
         end
      end
   end

   // ==========================================
   // register writes and snapshots
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_q <= `SPC_MODE_RST;
         mult_q <= `SPC_MULT_RST;
         en_q <= `SPC_EN_RST;
         clr_q <= 1'b0;
         scale_q <= `SPC_SCALE_RST;
         tot_scale_q <= `SPC_TOT_SCALE_RST;
         proc_hi_snap_q <= 32'h00000000;
         tot_hi_snap_q <= 32'h00000000;
      end
      else
      begin
         clr_q <= 1'b0;
         if (wr_go)
         begin
            case (paddr)
               `SPC_OFF_CTRL:
               begin
                  mode_q <= pwdata[`SPC_CTRL_MODE_MSB:`SPC_CTRL_MODE_LSB];
                  mult_q <= pwdata[`SPC_CTRL_MULT_MSB:`SPC_CTRL_MULT_LSB];
                  en_q <= pwdata[`SPC_CTRL_EN_BIT];
                  clr_q <= pwdata[`SPC_CTRL_CLR_BIT];
               end
               `SPC_OFF_SCALE: scale_q <= wr_scale;
               `SPC_OFF_TOT_SCALE: tot_scale_q <= wr_scale;
               default: clr_q <= 1'b0;
            endcase
         end
         // low word read freezes the matching high word
         if (rd_first & (paddr == `SPC_OFF_PROC_LO))
         begin
            proc_hi_snap_q <= proc_val[63:32];
         end
         if (rd_first & (paddr == `SPC_OFF_TOT_LO))
         begin
            tot_hi_snap_q <= tot_val[63:32];
         end
      end
   end

   // ==========================================
   // counted edge tally
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         edges_q <= 32'h00000000;
      end
      else if (clr_q)
      begin
         edges_q <= 32'h00000000;
      end
      else if (ev_go)
      begin
         edges_q <= edges_q + 32'h00000001;
      end
   end

endmodule

`default_nettype wire

// File: tb/spc_top_sva.sv
// apb port assertions for the scaled pulse counter
`timescale 1ns/1ps
`default_nettype none
module spc_top_sva
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pulse_a,
   input wire logic dir_b
);
   // ==========
   // helpers
   logic wr_q;
   logic rd;
   assign rd = pready && psel && !pwrite;
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         wr_q <= 1'b0;
      else if (pready && psel && pwrite)
         wr_q <= 1'b1;
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // ==========
   // properties
   rdy_after_access_a: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   rdy_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready held");
   rdy_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   err_zero_data_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
      else $error("bad error answer");
   ctrl_reset_a: assert property (rd && paddr == 8'h00 && !wr_q |-> prdata[8:0] == 9'h010)
      else $error("control default");
   scale_reset_a: assert property (rd && paddr == 8'h04 && !wr_q |-> prdata[15:0] == 16'h2710)
      else $error("scale default");
   tot_reset_a: assert property (rd && paddr == 8'h08 && !wr_q |-> prdata[15:0] == 16'h2710)
      else $error("total scale default");
   scale_limit_a: assert property (rd && paddr inside {8'h04, 8'h08} |-> prdata[15:0] <= 16'hea5f)
      else $error("scale above limit");
   status_bits_a: assert property (rd && paddr == 8'h20 |-> prdata[31:2] == 30'h0)
      else $error("status spare bits");
endmodule
bind spc_top spc_top_sva u_sva (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pulse_a(pulse_a), .dir_b(dir_b));
`default_nettype wire

// File: tb/spc_pulse_src.sv
// pulse sensor and quadrature encoder model
`timescale 1ns/1ps
`default_nettype none
module spc_pulse_src
(
   input wire logic clk_sys,
   output logic pulse_a,
   output logic dir_b
);
   initial
   begin
      pulse_a = 1'b0;
      dir_b = 1'b0;
   end
   // each level held four clocks
   task automatic step(input logic a, input logic b);
      pulse_a <= a;
      dir_b <= b;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic pulses(input int n, input logic down);
      step(1'b0, down);
      repeat (n)
      begin
         step(1'b1, down);
         step(1'b0, down);
      end
   endtask
   // channel a leads b, one change per step
   task automatic quad(input int n);
      repeat (n)
      begin
         step(1'b1, 1'b0);
         step(1'b1, 1'b1);
         step(1'b0, 1'b1);
         step(1'b0, 1'b0);
      end
   endtask
endmodule
`default_nettype wire

// File: tb/tb_scaled_pulse_counter.sv
// self-checking bench for the scaled pulse counter
`timescale 1ns/1ps
`default_nettype none
module tb_scaled_pulse_counter;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pulse_a;
   logic dir_b;
   int err_total = 0;
   int checked = 0;
   always #20 clk_sys = ~clk_sys;
   spc_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pulse_a(pulse_a), .dir_b(dir_b));
   spc_pulse_src src (.clk_sys(clk_sys), .pulse_a(pulse_a), .dir_b(dir_b));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ==========
   // apb master
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
      begin
         @(posedge clk_sys);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk({32'h0, q}, {32'h0, exp});
   endtask
   task automatic rd64(input logic [7:0] a, input logic signed [63:0] exp);
      logic [31:0] lo;
      logic [31:0] hi;
      logic e;
      apb(1'b0, a, 32'h0, lo, e);
      apb(1'b0, a + 8'h04, 32'h0, hi, e);
      chk({hi, lo}, exp);
   endtask
   task automatic counts(input logic signed [63:0] p, input logic [15:0] ts,
      input logic [31:0] ed);
      repeat (4) @(posedge clk_sys);
      rd64(8'h0c, p);
      rd64(8'h14, p * $signed({48'h0, ts}));
      rdc(8'h1c, ed);
   endtask
   // ==========
   // scenarios
   task automatic t_defaults;
      logic [31:0] q;
      logic e;
      rdc(8'h00, 32'h10);
      rdc(8'h04, 32'h2710);
      rdc(8'h08, 32'h2710);
      rdc(8'h20, 32'h0);
      apb(1'b0, 8'h24, 32'h0, q, e);
      chk({63'h0, e}, 64'h1);
   endtask
   task automatic t_single;
      src.pulses(3, 1'b0);
      counts(64'd3000000, 16'h2710, 32'd3);
   endtask
   task automatic t_double;
      wr(8'h00, 32'h111);
      src.pulses(2, 1'b0);
      counts(64'd4000000, 16'h2710, 32'd4);
      src.pulses(1, 1'b1);
      repeat (4) @(posedge clk_sys);
      rd64(8'h0c, 64'd2000000);
   endtask
   task automatic t_quad;
      // direction back to idle while still in double mode
      src.step(1'b0, 1'b0);
      wr(8'h00, 32'h112);
      src.quad(2);
      counts(64'd8000000, 16'h2710, 32'd8);
      // both channels at once are ignored, then one down step
      src.step(1'b1, 1'b1);
      src.step(1'b0, 1'b0);
      src.step(1'b0, 1'b1);
      counts(64'd7000000, 16'h2710, 32'd9);
      rdc(8'h20, 32'h2);
   endtask
   task automatic t_mult;
      logic [63:0] fac[3] = '{64'd100, 64'd10, 64'd1};
      wr(8'h04, 32'hffff);
      rdc(8'h04, 32'hea5f);
      wr(8'h04, 32'd6250);
      wr(8'h08, 32'd3048);
      for (int m = 0; m < 3; m++)
      begin
         wr(8'h00, 32'h110 | (m << 2));
         src.pulses(1, 1'b0);
         counts(64'd6250 * fac[m], 16'd3048, 32'd1);
      end
   endtask
   task automatic t_disable;
      wr(8'h00, 32'h100);
      src.pulses(2, 1'b0);
      counts(64'd0, 16'd3048, 32'd0);
   endtask
   // spare mode and multiplier codes act as single edge, times one
   task automatic t_spare;
      wr(8'h00, 32'h11f);
      src.pulses(2, 1'b1);
      counts(-64'sd1250000, 16'd3048, 32'd2);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      t_defaults();
      t_single();
      t_double();
      t_quad();
      t_mult();
      t_disable();
      t_spare();
      report_and_stop();
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      report_and_stop();
   end
endmodule
`default_nettype wire
